// ---- verilog/dtc_timer.sv ----
`timescale 1ns/1ps

// Contract
// - Clock-mode bit 0 counts sysclk/12 ticks, 1 counts every sysclk.
// - Output-enable bit drives the timer output onto its own count pin.
// - 13-bit mode uses high byte plus low five bits of low byte.
// - Count only when run set and gate clear or interrupt pin high.
// - 13-bit wrap 1FFF to 0 sets overflow flag and interrupt.
// - 16-bit wrap FFFF to 0 sets overflow flag and interrupt.
// - Reload mode: low byte overflows, reloads from high byte, keeps counting.
// - Only timer 1 overflows feed the serial port baud rate.
// - Timer 1 in split mode holds its count and stops.
// - Split mode: timer 0 low byte uses timer 0 controls and flag.
// - Split mode: timer 0 high byte counts clocks, timer 1 run and flag.
// - Timer 1 runs by leaving split mode, keeps gate, pin, clock mode.
// - Timer 0 split: timer 1 ignores its run bit, never sets flag.
// - Counter-select 0 counts internal clock, 1 counts pin falling edges.
// - Overflow flags clear on service entry; software may set or clear.
// - Clearing run halts the timer and keeps both count bytes.

module dtc_timer (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire dtc_pkg::dtc_bus_req_s bus_req,
  output logic [7:0]                rd_data,
  input  wire logic                 timer0_count_pin_in,
  output logic                      timer0_count_pin_out,
  output logic                      timer0_count_pin_oe,
  input  wire logic                 timer1_count_pin_in,
  output logic                      timer1_count_pin_out,
  output logic                      timer1_count_pin_oe,
  input  wire logic                 ext_interrupt0_pin,
  input  wire logic                 ext_interrupt1_pin,
  input  wire logic                 isr_enter0,
  input  wire logic                 isr_enter1,
  output logic                      timer0_overflow_flag,
  output logic                      timer1_overflow_flag,
  output logic                      baud_tick,
  output logic                      irq
);

  dtc_pkg::dtc_state_s state;
  dtc_pkg::dtc_state_s next_state;

  logic fall0;
  logic fall1;

  dtc_fall_detect u_fall0 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (timer0_count_pin_in),
    .fall    (fall0)
  );

  dtc_fall_detect u_fall1 (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .pin     (timer1_count_pin_in),
    .fall    (fall1)
  );

  // One counting step of a timer in any of its four modes
  function automatic dtc_pkg::dtc_cnt_s step(
    input dtc_pkg::dtc_mode_e mode,
    input logic [7:0]         lo,
    input logic [7:0]         hi,
    input logic               inc
  );
    dtc_pkg::dtc_cnt_s r;
    logic [12:0]       v13;
    logic [15:0]       v16;
    r.lo  = lo;
    r.hi  = hi;
    r.ovf = 1'b0;
    v13   = {hi, lo[4:0]} + 13'h0001;
    v16   = {hi, lo} + 16'h0001;
    if (inc) begin
      unique case (mode)
        dtc_pkg::MODE_13: begin
          // Upper three low-byte bits stay untouched
          r.lo  = {lo[7:5], v13[4:0]};
          r.hi  = v13[12:5];
          r.ovf = ({hi, lo[4:0]} == dtc_pkg::CNT13_MAX);
        end
        dtc_pkg::MODE_16: begin
          r.lo  = v16[7:0];
          r.hi  = v16[15:8];
          r.ovf = ({hi, lo} == dtc_pkg::CNT16_MAX);
        end
        dtc_pkg::MODE_RELOAD: begin
          r.ovf = (lo == dtc_pkg::CNT8_MAX);
          r.lo  = r.ovf ? hi : lo + 8'h01;
        end
        dtc_pkg::MODE_SPLIT: begin
          r.ovf = (lo == dtc_pkg::CNT8_MAX);
          r.lo  = lo + 8'h01;
        end
      endcase
    end
    return r;
  endfunction : step

  dtc_pkg::dtc_mode_e mode0;
  dtc_pkg::dtc_mode_e mode1;
  logic               split0;
  logic               tick_div;
  logic               clk0;
  logic               clk1;
  logic               inc0;
  logic               inc1;
  logic               gate_ok0;
  logic               gate_ok1;
  logic               en0;
  logic               en1;
  logic               en_hi0;
  dtc_pkg::dtc_cnt_s  cnt0;
  dtc_pkg::dtc_cnt_s  cnt1;
  logic [7:0]         hi0_split;
  logic               ovf_hi0;
  logic               set_tf0;
  logic               set_tf1;
  logic               wr_ctl;
  logic               rd_status;
  logic [7:0]         rd_mux;

  always_comb begin
    mode0  = dtc_pkg::dtc_mode_e'(
               state.mode[dtc_pkg::MODE_M0_LO +: 2]);
    mode1  = dtc_pkg::dtc_mode_e'(
               state.mode[dtc_pkg::MODE_M1_LO +: 2]);
    split0 = (mode0 == dtc_pkg::MODE_SPLIT);

    tick_div = (state.div == dtc_pkg::DIV_LAST);
    clk0 = state.clk_sel[dtc_pkg::CKS_T0M] | tick_div;
    clk1 = state.clk_sel[dtc_pkg::CKS_T1M] | tick_div;

    inc0 = state.mode[dtc_pkg::MODE_CT0] ? fall0 : clk0;
    inc1 = state.mode[dtc_pkg::MODE_CT1] ? fall1 : clk1;

    gate_ok0 = ~state.mode[dtc_pkg::MODE_GATE0]
             | ext_interrupt0_pin;
    gate_ok1 = ~state.mode[dtc_pkg::MODE_GATE1]
             | ext_interrupt1_pin;

    // A cleared run bit simply withholds the increment
    en0 = state.run0 & gate_ok0;
    // Split timer 0 takes the run bit; mode 3 and the gate start or stop
    if (split0) begin
      en1 = gate_ok1;
    end else begin
      en1 = state.run1 & gate_ok1;
    end
    if (mode1 == dtc_pkg::MODE_SPLIT) begin
      en1 = 1'b0;
    end

    en_hi0 = split0 & state.run1 & clk0;

    cnt0 = step(mode0, state.tl0, state.th0, inc0 & en0);
    cnt1 = step(mode1, state.tl1, state.th1, inc1 & en1);

    hi0_split = state.th0;
    ovf_hi0   = 1'b0;
    if (en_hi0) begin
      hi0_split = state.th0 + 8'h01;
      ovf_hi0   = (state.th0 == dtc_pkg::CNT8_MAX);
    end

    set_tf0 = cnt0.ovf;
    // Timer 1 loses its flag while timer 0 is split
    if (split0) begin
      set_tf1 = ovf_hi0;
    end else begin
      set_tf1 = cnt1.ovf;
    end

    wr_ctl    = bus_req.wr & (bus_req.addr == dtc_pkg::ADDR_CONTROL);
    rd_status = bus_req.rd
              & (bus_req.addr == dtc_pkg::ADDR_INT_STATUS);

    unique case (bus_req.addr)
      dtc_pkg::ADDR_CONTROL: begin
        rd_mux = 8'h00;
        rd_mux[dtc_pkg::CTL_TF1] = state.tf1;
        rd_mux[dtc_pkg::CTL_TR1] = state.run1;
        rd_mux[dtc_pkg::CTL_TF0] = state.tf0;
        rd_mux[dtc_pkg::CTL_TR0] = state.run0;
      end
      dtc_pkg::ADDR_MODE:         rd_mux = state.mode;
      dtc_pkg::ADDR_T0_LOW:       rd_mux = state.tl0;
      dtc_pkg::ADDR_T1_LOW:       rd_mux = state.tl1;
      dtc_pkg::ADDR_T0_HIGH:      rd_mux = state.th0;
      dtc_pkg::ADDR_T1_HIGH:      rd_mux = state.th1;
      dtc_pkg::ADDR_CLOCK_SELECT: rd_mux = state.clk_sel;
      dtc_pkg::ADDR_PIN_SETTING:  rd_mux = state.pin_set;
      dtc_pkg::ADDR_INT_STATUS:   rd_mux = {6'h00, state.int_status};
      dtc_pkg::ADDR_INT_MASK:     rd_mux = {6'h00, state.int_mask};
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;

    if (tick_div) begin
      next_state.div = dtc_pkg::DIV_RESET;
    end else begin
      next_state.div = state.div + 4'h1;
    end

    // Counting first; a software write in the same cycle wins
    next_state.tl0 = cnt0.lo;
    next_state.th0 = split0 ? hi0_split : cnt0.hi;
    next_state.tl1 = cnt1.lo;
    next_state.th1 = cnt1.hi;

    next_state.tf0 = state.tf0;
    next_state.tf1 = state.tf1;
    if (isr_enter0) begin
      next_state.tf0 = 1'b0;
    end
    if (isr_enter1) begin
      next_state.tf1 = 1'b0;
    end

    if (bus_req.wr) begin
      unique case (bus_req.addr)
        dtc_pkg::ADDR_MODE: begin
          next_state.mode = bus_req.wdata;
        end
        dtc_pkg::ADDR_T0_LOW: begin
          next_state.tl0 = bus_req.wdata;
        end
        dtc_pkg::ADDR_T1_LOW: begin
          next_state.tl1 = bus_req.wdata;
        end
        dtc_pkg::ADDR_T0_HIGH: begin
          next_state.th0 = bus_req.wdata;
        end
        dtc_pkg::ADDR_T1_HIGH: begin
          next_state.th1 = bus_req.wdata;
        end
        dtc_pkg::ADDR_CLOCK_SELECT: begin
          next_state.clk_sel = bus_req.wdata & dtc_pkg::CKS_WMASK;
        end
        dtc_pkg::ADDR_PIN_SETTING: begin
          next_state.pin_set = bus_req.wdata & dtc_pkg::PIN_WMASK;
        end
        dtc_pkg::ADDR_INT_MASK: begin
          next_state.int_mask = bus_req.wdata[1:0];
        end
        default: begin
          next_state.mode = state.mode;
        end
      endcase
    end
    if (wr_ctl) begin
      next_state.tf1  = bus_req.wdata[dtc_pkg::CTL_TF1];
      next_state.run1 = bus_req.wdata[dtc_pkg::CTL_TR1];
      next_state.tf0  = bus_req.wdata[dtc_pkg::CTL_TF0];
      next_state.run0 = bus_req.wdata[dtc_pkg::CTL_TR0];
    end

    // Hardware set beats any clear in the same cycle
    if (set_tf0) begin
      next_state.tf0 = 1'b1;
    end
    if (set_tf1) begin
      next_state.tf1 = 1'b1;
    end

    // Sticky event bits; a read clears, but a fresh event survives
    if (rd_status) begin
      next_state.int_status = dtc_pkg::INT_RESET;
    end
    if (set_tf0) begin
      next_state.int_status[dtc_pkg::INT_T0] = 1'b1;
    end
    if (set_tf1) begin
      next_state.int_status[dtc_pkg::INT_T1] = 1'b1;
    end
    next_state.irq = |(next_state.int_status & next_state.int_mask);

    // Baud source is timer 1's own counter, split or not
    next_state.baud_tick = cnt1.ovf;

    next_state.t0_oe = next_state.pin_set[dtc_pkg::PIN_T0OE];
    next_state.t1_oe = next_state.pin_set[dtc_pkg::PIN_TIMER1_OUTPUT_ENABLE];
    // Toggling while disabled would leave a stale level at enable
    if (state.t0_oe & cnt0.ovf) begin
      next_state.t0_out = ~state.t0_out;
    end
    if (state.t1_oe & cnt1.ovf) begin
      next_state.t1_out = ~state.t1_out;
    end

    // Read data stands one cycle only, zero otherwise
    if (bus_req.rd) begin
      next_state.rd_data = rd_mux;
    end else begin
      next_state.rd_data = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state.mode       <= dtc_pkg::REG_RESET;
      state.run0       <= 1'b0;
      state.run1       <= 1'b0;
      state.tf0        <= 1'b0;
      state.tf1        <= 1'b0;
      state.tl0        <= dtc_pkg::REG_RESET;
      state.th0        <= dtc_pkg::REG_RESET;
      state.tl1        <= dtc_pkg::REG_RESET;
      state.th1        <= dtc_pkg::REG_RESET;
      state.clk_sel    <= dtc_pkg::REG_RESET;
      state.pin_set    <= dtc_pkg::REG_RESET;
      state.div        <= dtc_pkg::DIV_RESET;
      state.int_status <= dtc_pkg::INT_RESET;
      state.int_mask   <= dtc_pkg::INT_RESET;
      state.rd_data    <= dtc_pkg::REG_RESET;
      state.irq        <= 1'b0;
      state.baud_tick  <= 1'b0;
      state.t0_out     <= dtc_pkg::PIN_OUT_RST;
      state.t1_out     <= dtc_pkg::PIN_OUT_RST;
      state.t0_oe      <= 1'b0;
      state.t1_oe      <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data              = state.rd_data;
  assign timer0_count_pin_out = state.t0_out;
  assign timer0_count_pin_oe  = state.t0_oe;
  assign timer1_count_pin_out = state.t1_out;
  assign timer1_count_pin_oe  = state.t1_oe;
  assign timer0_overflow_flag = state.tf0;
  assign timer1_overflow_flag = state.tf1;
  assign baud_tick            = state.baud_tick;
  assign irq                  = state.irq;

endmodule : dtc_timer

// ---- verilog/dtc_pkg.sv ----
package dtc_pkg;

  // Register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_CONTROL      = 8'h88;
  localparam logic [7:0] ADDR_MODE         = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW       = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW       = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH      = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH      = 8'h8D;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8E;
  localparam logic [7:0] ADDR_PIN_SETTING  = 8'hB5;
  localparam logic [7:0] ADDR_INT_STATUS   = 8'hE8;
  localparam logic [7:0] ADDR_INT_MASK     = 8'hE9;

  // Mode register fields
  localparam int MODE_GATE1 = 7;
  localparam int MODE_CT1   = 6;
  localparam int MODE_M1_LO = 4;
  localparam int MODE_GATE0 = 3;
  localparam int MODE_CT0   = 2;
  localparam int MODE_M0_LO = 0;

  // Control register fields
  localparam int CTL_TF1 = 7;
  localparam int CTL_TR1 = 6;
  localparam int CTL_TF0 = 5;
  localparam int CTL_TR0 = 4;

  // Clock select and pin setting fields
  localparam int CKS_T1M  = 4;
  localparam int CKS_T0M  = 3;
  localparam int PIN_TIMER1_OUTPUT_ENABLE = 3;
  localparam int PIN_T0OE = 2;

  // Bits that hold storage; the rest read as zero
  localparam logic [7:0] CKS_WMASK = 8'h5A;
  localparam logic [7:0] PIN_WMASK = 8'h8D;

  // Interrupt status and mask bits
  localparam int INT_T0 = 0;
  localparam int INT_T1 = 1;

  // Values after reset
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [1:0] INT_RESET   = 2'h0;
  localparam logic       PIN_OUT_RST = 1'b1;
  localparam logic       FALL_RST    = 1'b1;

  // Prescaler: one enable pulse every twelve clocks
  localparam int         PRESCALE     = 12;
  localparam logic [3:0] DIV_LAST     = 4'(PRESCALE - 1);
  localparam logic [3:0] DIV_RESET    = 4'h0;

  // Counter limits
  localparam logic [12:0] CNT13_MAX = 13'h1FFF;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;
  localparam logic [7:0]  CNT8_MAX  = 8'hFF;

  typedef enum logic [1:0] {
    MODE_13,
    MODE_16,
    MODE_RELOAD,
    MODE_SPLIT
  } dtc_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dtc_bus_req_s;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } dtc_cnt_s;

  typedef struct packed {
    logic prev;
  } dtc_fall_s;

  typedef struct packed {
    logic [7:0] mode;
    logic       run0;
    logic       run1;
    logic       tf0;
    logic       tf1;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] clk_sel;
    logic [7:0] pin_set;
    logic [3:0] div;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [7:0] rd_data;
    logic       irq;
    logic       baud_tick;
    logic       t0_out;
    logic       t1_out;
    logic       t0_oe;
    logic       t1_oe;
  } dtc_state_s;

endpackage : dtc_pkg

// ---- verilog/dtc_fall_detect.sv ----
`timescale 1ns/1ps

module dtc_fall_detect (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      fall
);

  dtc_pkg::dtc_fall_s state;
  dtc_pkg::dtc_fall_s next_state;

  always_comb begin
    next_state      = state;
    next_state.prev = pin;
  end

  // Idle-high reset makes a pin held low at release count as one falling edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state.prev <= dtc_pkg::FALL_RST;
    end else begin
      state <= next_state;
    end
  end

  assign fall = state.prev & ~pin;

endmodule : dtc_fall_detect

// ---- dv/dtc_pins.sv ----
`timescale 1ns/1ps

module dtc_pins (
  input  wire logic pin0_out,
  input  wire logic pin0_oe,
  input  wire logic pin1_out,
  input  wire logic pin1_oe,
  input  wire logic src0,
  input  wire logic src1,
  output logic      pin0,
  output logic      pin1
);
  // Count pins are pulled up; the outside source only drives while the
  // device leaves the pin alone, so there is never a fight on the wire
  assign pin0 = pin0_oe ? pin0_out : src0;
  assign pin1 = pin1_oe ? pin1_out : src1;
endmodule : dtc_pins

// ---- dv/dtc_chk.sv ----
`timescale 1ns/1ps

module dtc_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire dtc_pkg::dtc_bus_req_s bus_req,
  input wire logic                  timer0_count_pin_out,
  input wire logic                  timer0_count_pin_oe,
  input wire logic                  timer1_count_pin_out,
  input wire logic                  timer1_count_pin_oe,
  input wire logic                  isr_enter0,
  input wire logic                  isr_enter1,
  input wire logic                  timer0_overflow_flag,
  input wire logic                  timer1_overflow_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic wr_pin;
  logic wr_ctl;
  assign wr_pin = bus_req.wr && bus_req.addr == dtc_pkg::ADDR_PIN_SETTING;
  assign wr_ctl = bus_req.wr && bus_req.addr == dtc_pkg::ADDR_CONTROL;

  a_oe0_follow: assert property (
    wr_pin |=> timer0_count_pin_oe == $past(bus_req.wdata[2]))
    else $error("timer 0 pin enable does not follow its bit");
  a_oe1_follow: assert property (
    wr_pin |=> timer1_count_pin_oe == $past(bus_req.wdata[3]))
    else $error("timer 1 pin enable does not follow its bit");
  a_out0_quiet: assert property (
    $changed(timer0_count_pin_out) |-> $past(timer0_count_pin_oe))
    else $error("timer 0 output moved while disabled");
  a_out1_quiet: assert property (
    $changed(timer1_count_pin_out) |-> $past(timer1_count_pin_oe))
    else $error("timer 1 output moved while disabled");
  a_out0_toggle: assert property (
    $rose(timer0_overflow_flag) && !$past(wr_ctl)
      && timer0_count_pin_oe && $past(timer0_count_pin_oe)
      |-> $changed(timer0_count_pin_out))
    else $error("timer 0 output missed an overflow");
  a_tf0_hold: assert property (
    $fell(timer0_overflow_flag) |-> $past(isr_enter0 || wr_ctl))
    else $error("timer 0 flag dropped on its own");
  a_tf1_hold: assert property (
    $fell(timer1_overflow_flag) |-> $past(isr_enter1 || wr_ctl))
    else $error("timer 1 flag dropped on its own");
  a_tf0_swset: assert property (
    wr_ctl && bus_req.wdata[5] |=> timer0_overflow_flag)
    else $error("timer 0 flag not set by software");
endmodule : dtc_chk

bind dtc_timer dtc_chk u_chk (.*);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic                  ref_clk    = 1'b0;
  logic                  rst_b      = 1'b0;
  dtc_pkg::dtc_bus_req_s bus_req    = '0;
  logic                  src0       = 1'b1;
  logic                  gate0      = 1'b0;
  logic                  isr1       = 1'b0;
  logic [7:0]            rd_data;
  logic                  pin0, pin1, out0, oe0, out1, oe1;
  logic                  tf0, tf1, baud_tick, irq;
  int                    err_count  = 0;
  int                    n_compared = 0;
  int                    n_baud     = 0;
  logic [7:0] t_mode [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] t_th   [4] = '{8'hFF, 8'hFF, 8'h80, 8'h80};
  logic [7:0] t_tl   [4] = '{8'hE3, 8'h03, 8'h83, 8'h03};
  logic [7:0] t_the  [4] = '{8'h00, 8'h00, 8'h80, 8'h80};

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (baud_tick === 1'b1) n_baud <= n_baud + 1;

  dtc_timer u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .timer0_count_pin_in(pin0),
    .timer0_count_pin_out(out0), .timer0_count_pin_oe(oe0),
    .timer1_count_pin_in(pin1), .timer1_count_pin_out(out1),
    .timer1_count_pin_oe(oe1), .ext_interrupt0_pin(gate0),
    .ext_interrupt1_pin(1'b1), .isr_enter0(1'b0), .isr_enter1(isr1),
    .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1),
    .baud_tick(baud_tick), .irq(irq));

  dtc_pins u_pins (
    .pin0_out(out0), .pin0_oe(oe0), .pin1_out(out1), .pin1_oe(oe1),
    .src0(src0), .src1(1'b1), .pin0(pin0), .pin1(pin1));

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string what);
    acc(a, 8'h00, 1'b0);
    #1 chk(what, e, rd_data);
  endtask : rd

  // Counts run for n+2 edges: the stop write is taken two edges later
  task automatic spin(input logic [7:0] ctl, input int n);
    wr(dtc_pkg::ADDR_CONTROL, ctl);
    repeat (n) @(posedge ref_clk);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
  endtask : spin

  task automatic finish_test;
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    logic exp_out;
    exp_out = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(dtc_pkg::ADDR_CLOCK_SELECT, 8'h00, "clock select");
    rd(dtc_pkg::ADDR_PIN_SETTING, 8'h00, "pin setting");
    wr(dtc_pkg::ADDR_CLOCK_SELECT, 8'hFF);
    rd(dtc_pkg::ADDR_CLOCK_SELECT, dtc_pkg::CKS_WMASK, "clock sel");
    wr(dtc_pkg::ADDR_PIN_SETTING, 8'hFF);
    rd(dtc_pkg::ADDR_PIN_SETTING, dtc_pkg::PIN_WMASK, "pin set");
    rd(8'h00, 8'h00, "unmapped");
    wr(dtc_pkg::ADDR_CLOCK_SELECT, 8'h08);
    wr(dtc_pkg::ADDR_PIN_SETTING, 8'h04);
    wr(dtc_pkg::ADDR_INT_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(dtc_pkg::ADDR_MODE, t_mode[i]);
      wr(dtc_pkg::ADDR_T0_LOW, 8'hFE);
      wr(dtc_pkg::ADDR_T0_HIGH, t_th[i]);
      wr(dtc_pkg::ADDR_CONTROL, 8'h10);
      repeat (3) @(posedge ref_clk);
      #1 chk("flag 0", 8'h01, {7'h00, tf0});
      chk("irq", 8'h01, {7'h00, irq});
      wr(dtc_pkg::ADDR_CONTROL, 8'h00);
      rd(dtc_pkg::ADDR_T0_LOW, t_tl[i], "low 0");
      rd(dtc_pkg::ADDR_T0_HIGH, t_the[i], "high 0");
      rd(dtc_pkg::ADDR_INT_STATUS, 8'h01, "status");
      @(posedge ref_clk);
      #1 chk("irq", 8'h00, {7'h00, irq});
      exp_out = ~exp_out;
      chk("out 0", {7'h00, exp_out}, {7'h00, out0});
    end
    chk("baud ticks", 8'h00, 8'(n_baud));
    wr(dtc_pkg::ADDR_PIN_SETTING, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h09);
    wr(dtc_pkg::ADDR_T0_LOW, 8'h00);
    spin(8'h10, 3);
    rd(dtc_pkg::ADDR_T0_LOW, 8'h00, "gated low");
    @(posedge ref_clk);
    gate0 <= 1'b1;
    spin(8'h10, 3);
    rd(dtc_pkg::ADDR_T0_LOW, 8'h05, "gate open");
    wr(dtc_pkg::ADDR_CLOCK_SELECT, 8'h00);
    wr(dtc_pkg::ADDR_MODE, 8'h01);
    wr(dtc_pkg::ADDR_T0_LOW, 8'h00);
    spin(8'h10, 22);
    rd(dtc_pkg::ADDR_T0_LOW, 8'h02, "divided");
    wr(dtc_pkg::ADDR_MODE, 8'h05);
    wr(dtc_pkg::ADDR_T0_LOW, 8'h00);
    wr(dtc_pkg::ADDR_CONTROL, 8'h10);
    repeat (3) begin
      @(posedge ref_clk);
      src0 <= 1'b0;
      repeat (2) @(posedge ref_clk);
      src0 <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    rd(dtc_pkg::ADDR_T0_LOW, 8'h03, "pin edges");
    wr(dtc_pkg::ADDR_CLOCK_SELECT, 8'h10);
    wr(dtc_pkg::ADDR_MODE, 8'h10);
    wr(dtc_pkg::ADDR_T1_LOW, 8'hFE);
    wr(dtc_pkg::ADDR_T1_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_CONTROL, 8'h40);
    repeat (3) @(posedge ref_clk);
    #1 chk("flag 1", 8'h01, {7'h00, tf1});
    chk("masked irq", 8'h00, {7'h00, irq});
    @(posedge ref_clk);
    isr1 <= 1'b1;
    @(posedge ref_clk);
    isr1 <= 1'b0;
    #1 chk("flag 1 isr", 8'h00, {7'h00, tf1});
    wr(dtc_pkg::ADDR_CONTROL, 8'h00);
    chk("baud ticks", 8'h01, 8'(n_baud));
    rd(dtc_pkg::ADDR_INT_STATUS, 8'h02, "status");
    wr(dtc_pkg::ADDR_MODE, 8'h30);
    wr(dtc_pkg::ADDR_T1_LOW, 8'h55);
    spin(8'h40, 3);
    rd(dtc_pkg::ADDR_T1_LOW, 8'h55, "halted low 1");
    wr(dtc_pkg::ADDR_CLOCK_SELECT, 8'h18);
    wr(dtc_pkg::ADDR_MODE, 8'h33);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hFE);
    spin(8'h40, 3);
    rd(dtc_pkg::ADDR_T0_HIGH, 8'h03, "split high");
    rd(dtc_pkg::ADDR_INT_STATUS, 8'h02, "split status");
    finish_test();
  end
endmodule : testbench
